// ---- core/ppm_consts.svh ----
// Register offsets, field positions and reset values of the parallel ports
`ifndef PPM_CONSTS_SVH
`define PPM_CONSTS_SVH
`define PPM_OFF_A_DATA 4'h0
`define PPM_OFF_B_DATA 4'h1
`define PPM_OFF_C_DATA 4'h2
`define PPM_OFF_D_DATA 4'h3
`define PPM_OFF_A_DIR 4'h4
`define PPM_OFF_B_DIR 4'h5
`define PPM_OFF_C_DIR 4'h6
`define PPM_OFF_D_DIR 4'h7
`define PPM_OFF_PWM_SEL 4'ha
`define PPM_OFF_SYNC_SEL 4'hb
`define PPM_SYNC_SDA_BIT 0
`define PPM_SYNC_SCL_BIT 1
`define PPM_SYNC_VERT_BIT 6
`define PPM_SYNC_HORZ_BIT 7
`define PPM_SYNC_MASK 8'hc3
`define PPM_CFG_RESET 8'h00
`define PPM_DIR_RESET 8'h00
`endif

// ---- core/ppm_pkg.sv ----
// Types shared by the parallel port block
package ppm_pkg;
    // Alternate-function sources for third and fourth port pins
    typedef struct packed {
        logic [7:0] pwm;
        logic horz_sync;
        logic vert_sync;
        logic ser_clk_low;
        logic ser_dat_low;
    } ppm_alt_s;
    // Pin pair (value and enable) for an eight-bit group
    typedef struct packed {
        logic [7:0] o;
        logic [7:0] oe;
    } ppm_pin_s;
endpackage

// ---- core/ppm_ports.sv ----
// Four parallel ports with direction, read-back and pin multiplexing
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ps
`include "ppm_consts.svh"

module ppm_ports (
    input wire logic clk_i, // System clock, 10 MHz
    input wire logic rst_i, // Synchronous reset, active high
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    input wire logic wb_we_i, // Wishbone write enable
    input wire logic [3:0] wb_adr_i, // Word index of register
    input wire logic [3:0] wb_sel_i, // Byte lanes, lane 0 used
    input wire logic [31:0] wb_dat_i, // Write data
    output logic [31:0] wb_dat_o, // Read data
    output logic wb_ack_o, // Acknowledge
    input wire logic [7:0] first_port_lines_i, // First port pin levels
    output logic [7:0] first_port_lines_o, // First port drive value
    output logic [7:0] first_port_lines_oe_o, // First port drive enable
    input wire logic [5:0] second_port_lines_i, // Second port levels
    output logic [5:0] second_port_lines_o, // Second port drive value
    output logic [5:0] second_port_lines_oe_o, // Second port enable
    input wire logic [7:0] third_port_lines_i, // Third port levels
    output logic [7:0] third_port_lines_o, // Third port drive value
    output logic [7:0] third_port_lines_oe_o, // Third port enable
    input wire logic [1:0] fourth_port_lines_i, // Fourth port levels
    output logic [1:0] fourth_port_lines_o, // Fourth port drive value
    output logic [1:0] fourth_port_lines_oe_o, // Fourth port enable
    input wire ppm_pkg::ppm_alt_s alt_i, // Alternate-function sources
    output logic [7:0] pulse_width_route_bits_o, // Pulse-width selection
    output logic horizontal_sync_out_route_o, // Horizontal sync routed
    output logic vertical_sync_out_route_o, // Vertical sync routed
    output logic [1:0] serial_route_o // Serial clock/data routed
);

    ////////////////////////////////////////////////////////////////////
    // Register state
    // Output latches, never reset
    logic [7:0] a_lat_q; // First port latch
    logic [5:0] b_lat_q; // Second port latch
    logic [7:0] c_lat_q; // Third port latch
    logic [1:0] d_lat_q; // Fourth port latch
    // Direction registers, one means drive
    logic [7:0] a_dir_q; // First port direction
    logic [5:0] b_dir_q; // Second port direction
    logic [7:0] c_dir_q; // Third port direction
    logic [1:0] d_dir_q; // Fourth port direction
    // Pin-select configuration
    logic [7:0] pwm_sel_q; // Pulse-width routes
    logic [7:0] sync_sel_q; // Sync and serial routes
    logic ack_q;
    logic [31:0] rdat_q;
    logic [7:0] rdat_d;
    logic wr_en, rd_en;
    logic [7:0] wbyte;
    // Pin synchronisers: three stages, change accepted when 2 and 3 agree
    logic [23:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_q;
    logic [23:0] pin_raw;
    // Filtered pin levels per port, as the read path sees them
    logic [7:0] a_pin;
    logic [5:0] b_pin;
    logic [7:0] c_pin;
    logic [1:0] d_pin;

    assign wbyte = wb_dat_i[7:0];
    // Write takes effect on the cycle ack rises, once per access
    // Reads need no lane select; writes only take lane 0
    assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q & wb_sel_i[0];
    assign rd_en = wb_cyc_i & wb_stb_i & ~ack_q;
    assign pin_raw = {fourth_port_lines_i, third_port_lines_i,
                      second_port_lines_i, first_port_lines_i};

    ////////////////////////////////////////////////////////////////////
    // Input synchronisers
    always_ff @(posedge clk_i)
    begin
        pin_s1_q <= pin_raw;
        pin_s2_q <= pin_s1_q;
        pin_s3_q <= pin_s2_q;
    end

    // Filtered level, stage 1 never looked at directly
    genvar gi;
    generate
        for (gi = 0; gi < 24; gi = gi + 1)
        begin : g_pin
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    pin_q[gi] <= 1'b0;
                else if (pin_s2_q[gi] == pin_s3_q[gi])
                    pin_q[gi] <= pin_s3_q[gi];
            end
        end
    endgenerate

    // Split the filtered word back into ports
    assign a_pin = pin_q[7:0];
    assign b_pin = pin_q[13:8];
    assign c_pin = pin_q[21:14];
    assign d_pin = pin_q[23:22];

    ////////////////////////////////////////////////////////////////////
    // Output latches: no reset, contents survive reset
    // latches keep value
    always_ff @(posedge clk_i)
    begin
        if (wr_en)
        begin
            case (wb_adr_i)
                `PPM_OFF_A_DATA: a_lat_q <= wbyte;
                `PPM_OFF_B_DATA: b_lat_q <= wbyte[5:0];
                `PPM_OFF_C_DATA: c_lat_q <= wbyte;
                `PPM_OFF_D_DATA: d_lat_q <= wbyte[1:0];
                default: ;
            endcase
        end
    end

    // Direction registers
    // directions cleared
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            a_dir_q <= `PPM_DIR_RESET;
            b_dir_q <= 6'h00;
            c_dir_q <= `PPM_DIR_RESET;
            d_dir_q <= 2'h0;
        end
        else if (wr_en)
        begin
            case (wb_adr_i)
                `PPM_OFF_A_DIR: a_dir_q <= wbyte;
                `PPM_OFF_B_DIR: b_dir_q <= wbyte[5:0];
                `PPM_OFF_C_DIR: c_dir_q <= wbyte;
                `PPM_OFF_D_DIR: d_dir_q <= wbyte[1:0];
                default: ;
            endcase
        end
    end

    // Configuration registers
    // Second config keeps only its four defined bits
    // config reset zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pwm_sel_q <= `PPM_CFG_RESET;
            sync_sel_q <= `PPM_CFG_RESET;
        end
        else if (wr_en && wb_adr_i == `PPM_OFF_PWM_SEL)
            pwm_sel_q <= wbyte;
        else if (wr_en && wb_adr_i == `PPM_OFF_SYNC_SEL)
            sync_sel_q <= wbyte & `PPM_SYNC_MASK;
    end

    ////////////////////////////////////////////////////////////////////
    // Read mux
    // input reads pin
    always_comb
    begin
        rdat_d = 8'h00;
        case (wb_adr_i)
            `PPM_OFF_A_DATA:
                rdat_d = (a_dir_q & a_lat_q) | (~a_dir_q & a_pin);
            `PPM_OFF_B_DATA:
                rdat_d = {2'b00, (b_dir_q & b_lat_q)
                          | (~b_dir_q & b_pin)};
            `PPM_OFF_C_DATA:
                rdat_d = (c_dir_q & c_lat_q) | (~c_dir_q & c_pin);
            `PPM_OFF_D_DATA:
                rdat_d = {6'h00, (d_dir_q & d_lat_q)
                          | (~d_dir_q & d_pin)};
            `PPM_OFF_A_DIR: rdat_d = a_dir_q;
            `PPM_OFF_B_DIR: rdat_d = {2'b00, b_dir_q};
            `PPM_OFF_C_DIR: rdat_d = c_dir_q;
            `PPM_OFF_D_DIR: rdat_d = {6'h00, d_dir_q};
            `PPM_OFF_PWM_SEL: rdat_d = pwm_sel_q;
            `PPM_OFF_SYNC_SEL: rdat_d = sync_sel_q & `PPM_SYNC_MASK;
            default: rdat_d = 8'h00;
        endcase
    end

    // Bus answer one cycle after request; unmapped reads give zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            rdat_q <= 32'h00000000;
        end
        else
        begin
            ack_q <= rd_en;
            rdat_q <= {24'h000000, rdat_d};
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    ////////////////////////////////////////////////////////////////////
    // Pin drive, registered so outputs come from flip-flops
    logic [7:0] a_o_q, a_oe_q, c_o_q, c_oe_q;
    logic [5:0] b_o_q, b_oe_q;
    logic [1:0] d_o_q, d_oe_q;
    logic [7:0] c_o_d, c_oe_d;
    logic [1:0] d_o_d, d_oe_d;

    // Third port multiplexing, sync beats pulse-width beats port
    // pulse-width route
    always_comb
    begin
        c_o_d = c_lat_q;
        c_oe_d = c_dir_q;
        for (int k = 0; k < 8; k++)
        begin
            if (pwm_sel_q[k])
            begin
                c_o_d[k] = alt_i.pwm[k];
                c_oe_d[k] = 1'b1;
            end
        end
        if (sync_sel_q[`PPM_SYNC_VERT_BIT])
        begin
            c_o_d[6] = alt_i.vert_sync;
            c_oe_d[6] = 1'b1;
        end
        if (sync_sel_q[`PPM_SYNC_HORZ_BIT])
        begin
            c_o_d[7] = alt_i.horz_sync;
            c_oe_d[7] = 1'b1;
        end
    end

    // Fourth port: serial lines only pull low or release
    // Direction bits are ignored while the serial bus owns a pin
    // serial route
    always_comb
    begin
        d_o_d = d_lat_q;
        d_oe_d = d_dir_q;
        if (sync_sel_q[`PPM_SYNC_SDA_BIT])
        begin
            d_o_d[0] = 1'b0;
            d_oe_d[0] = alt_i.ser_dat_low;
        end
        if (sync_sel_q[`PPM_SYNC_SCL_BIT])
        begin
            d_o_d[1] = 1'b0;
            d_oe_d[1] = alt_i.ser_clk_low;
        end
    end

    // One cycle of pin latency buys glitch-free registered drive
    // First port drive follows latch and direction
    // direction drives
    always_ff @(posedge clk_i)
    begin
        a_o_q <= a_lat_q;
        if (rst_i)
            a_oe_q <= 8'h00;
        else
            a_oe_q <= a_dir_q;
    end

    // Third port drive after the alternate-function mux
    // third port drive
    always_ff @(posedge clk_i)
    begin
        c_o_q <= c_o_d;
        if (rst_i)
            c_oe_q <= 8'h00;
        else
            c_oe_q <= c_oe_d;
    end

    // Fourth port drive after the serial mux
    // fourth port drive
    always_ff @(posedge clk_i)
    begin
        d_o_q <= d_o_d;
        if (rst_i)
            d_oe_q <= 2'h0;
        else
            d_oe_q <= d_oe_d;
    end

    // Second port: upper four bits open-drain, enable only when low
    // A high level on these comes from the board pull-up only
    // open-drain upper bits
    always_ff @(posedge clk_i)
    begin
        b_o_q <= {4'h0, b_lat_q[1:0]};
        if (rst_i)
            b_oe_q <= 6'h00;
        else
            b_oe_q <= {b_dir_q[5:2] & ~b_lat_q[5:2], b_dir_q[1:0]};
    end

    assign first_port_lines_o = a_o_q;
    assign first_port_lines_oe_o = a_oe_q;
    assign second_port_lines_o = b_o_q;
    assign second_port_lines_oe_o = b_oe_q;
    assign third_port_lines_o = c_o_q;
    assign third_port_lines_oe_o = c_oe_q;
    assign fourth_port_lines_o = d_o_q;
    assign fourth_port_lines_oe_o = d_oe_q;
    assign pulse_width_route_bits_o = pwm_sel_q;
    assign horizontal_sync_out_route_o = sync_sel_q[`PPM_SYNC_HORZ_BIT];
    assign vertical_sync_out_route_o = sync_sel_q[`PPM_SYNC_VERT_BIT];
    assign serial_route_o = {sync_sel_q[`PPM_SYNC_SCL_BIT],
                             sync_sel_q[`PPM_SYNC_SDA_BIT]};

endmodule // ppm_ports

// ---- verif/ppm_checker.sv ----
// Bus and pin assertions for the parallel port block
`timescale 1ns/1ps
`include "ppm_consts.svh"
module ppm_checker (
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Reset
    input wire logic wb_cyc_i, // Cycle
    input wire logic wb_stb_i, // Strobe
    input wire logic wb_we_i, // Write
    input wire logic [3:0] wb_adr_i, // Index
    input wire logic [3:0] wb_sel_i, // Lanes
    input wire logic [31:0] wb_dat_i, // Write data
    input wire logic [31:0] wb_dat_o, // Read data
    input wire logic wb_ack_o, // Ack
    input wire logic [7:0] first_port_lines_oe_o, // First enable
    input wire logic [5:0] second_port_lines_o, // Second value
    input wire logic [5:0] second_port_lines_oe_o, // Second enable
    input wire logic [7:0] third_port_lines_o, // Third value
    input wire logic [7:0] third_port_lines_oe_o, // Third enable
    input wire logic [1:0] fourth_port_lines_o, // Fourth value
    input wire logic [1:0] fourth_port_lines_oe_o, // Fourth enable
    input wire ppm_pkg::ppm_alt_s alt_i, // Alternate sources
    input wire logic [7:0] pulse_width_route_bits_o, // Pulse routes
    input wire logic horizontal_sync_out_route_o, // Horizontal route
    input wire logic [1:0] serial_route_o // Serial routes
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic take;
    logic wr;
    // Request taken and byte-lane write qualifiers
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = take && wb_we_i && wb_sel_i[0];
    sequence s_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    a_ack_pulse: assert property (take |=> s_pulse)
        else $error("ack is not a single pulse");
    a_dir_oe: assert property (wr && wb_adr_i == `PPM_OFF_A_DIR |-> ##2
        first_port_lines_oe_o == $past(wb_dat_i[7:0], 2))
        else $error("first port enable differs from direction");
    a_pwm_route: assert property (wr && wb_adr_i == `PPM_OFF_PWM_SEL |=>
        pulse_width_route_bits_o == $past(wb_dat_i[7:0]))
        else $error("pulse route differs from write");
    // serial and horizontal sync routes follow write
    a_sync_route: assert property (wr && wb_adr_i == `PPM_OFF_SYNC_SEL |=>
        serial_route_o == $past(wb_dat_i[1:0])
        && horizontal_sync_out_route_o == $past(wb_dat_i[7]))
        else $error("serial or sync route differs");
    // upper second port never drives high
    a_drain_b: assert property (
        (second_port_lines_o[5:2] & second_port_lines_oe_o[5:2]) == 4'h0)
        else $error("second port drives high");
    a_ser_low: assert property (serial_route_o[0] && $past(serial_route_o[0])
        |-> !fourth_port_lines_o[0]
        && fourth_port_lines_oe_o[0] == $past(alt_i.ser_dat_low))
        else $error("serial data line misdriven");
    a_horz_pin: assert property (horizontal_sync_out_route_o
        && $past(horizontal_sync_out_route_o)
        |-> third_port_lines_o[7] == $past(alt_i.horz_sync))
        else $error("pin seven not horizontal sync");
    a_read_hi: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read bits set");
    a_rst_idle: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o
        && first_port_lines_oe_o == 8'h00 && third_port_lines_oe_o == 8'h00
        && second_port_lines_oe_o == 6'h00 && pulse_width_route_bits_o == 8'h00)
        else $error("reset left pins or routes active");
endmodule // ppm_checker

// ---- verif/testbench.sv ----
// Self-checking bench for the parallel port block
`timescale 1ns/1ps
`include "ppm_consts.svh"
module testbench;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, hs_r, vs_r;
    logic [3:0] wb_adr_i, wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [7:0] p, a_o, a_oe, c_o, c_oe, pwm_r, rnd, v, d;
    logic [5:0] b_o, b_oe;
    logic [1:0] d_o, d_oe, ser_r;
    logic [7:0] mk [4] = '{8'hff, 8'h3f, 8'hff, 8'h03};
    ppm_pkg::ppm_alt_s alt;
    logic [31:0] q [$];
    int num_errors = 0;
    int total_checks = 0;
    ppm_ports ppm_ports_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .first_port_lines_i(p), .first_port_lines_o(a_o),
        .first_port_lines_oe_o(a_oe), .second_port_lines_i(p[5:0]),
        .second_port_lines_o(b_o), .second_port_lines_oe_o(b_oe),
        .third_port_lines_i(p), .third_port_lines_o(c_o),
        .third_port_lines_oe_o(c_oe), .fourth_port_lines_i(p[1:0]),
        .fourth_port_lines_o(d_o), .fourth_port_lines_oe_o(d_oe), .alt_i(alt),
        .pulse_width_route_bits_o(pwm_r), .horizontal_sync_out_route_o(hs_r),
        .vertical_sync_out_route_o(vs_r), .serial_route_o(ser_r));
    ////////////////////////////////////////////////////////////////////////
    // Free-running 100 ns clock
    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // One classic cycle; waits on ack, the watchdog bounds a hang
    task automatic wb(input logic [3:0] a, input logic w, input logic [7:0] x,
        input logic [3:0] s);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= {24'h0, x};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        q.push_back({24'h0, e});
        wb(a, 1'b0, 8'h00, 4'h1);
    endtask
    // Feedback shift step for random bytes
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    ////////////////////////////////////////////////////////////////////////
    // Read data is compared with the oldest noted expectation
    always @(posedge clk_i)
        if (wb_ack_o === 1'b1 && !wb_we_i)
            chk(wb_dat_o, q.pop_front());
    // Watchdog, far beyond the fewer than two hundred cycles of the tests
    initial
    begin
        tick(20000);
        num_errors++;
        conclude();
    end
    initial
    begin
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
        {wb_adr_i, wb_sel_i, wb_dat_i, p, alt} = '0;
        rnd = 8'h15;
        tick(6);
        rst_i <= 1'b0;
        for (int i = 0; i < 13; i++)
            rd(4'(i), 8'h00);
        $display("test reset values done");
        for (int i = 0; i < 4; i++)
        begin
            rnd = lfsr(rnd);
            d = rnd;
            rnd = lfsr(rnd);
            v = rnd;
            rnd = lfsr(rnd);
            p <= rnd;
            alt.pwm <= rnd;
            wb(4'(i + 4), 1'b1, d, 4'h1);
            rd(4'(i + 4), d & mk[i]);
            wb(4'(i), 1'b1, v, 4'h1);
            tick(8);
            rd(4'(i), ((v & d) | (p & ~d)) & mk[i]);
            if (i == 0)
                chk({a_oe, a_o & d}, {d, v & d});
        end
        $display("test direction and data done");
        rnd = lfsr(rnd);
        wb(`PPM_OFF_PWM_SEL, 1'b1, rnd, 4'h1);
        rd(`PPM_OFF_PWM_SEL, rnd);
        chk(32'(pwm_r), 32'(rnd));
        chk(32'(c_oe & rnd), 32'(rnd));
        chk(32'(c_o & rnd), 32'(alt.pwm & rnd));
        wb(`PPM_OFF_SYNC_SEL, 1'b1, 8'hff, 4'h1);
        rd(`PPM_OFF_SYNC_SEL, `PPM_SYNC_MASK);
        alt.ser_dat_low <= 1'b1;
        alt.horz_sync <= 1'b1;
        tick(3);
        chk({hs_r, vs_r, ser_r, d_oe[0], d_o[0], c_o[7]}, 32'h7d);
        alt.ser_dat_low <= 1'b0;
        tick(3);
        chk(32'(d_oe[0]), 32'h0);
        wb(`PPM_OFF_SYNC_SEL, 1'b1, 8'h00, 4'h0);
        wb(4'h8, 1'b1, 8'h5a, 4'h1);
        rd(`PPM_OFF_SYNC_SEL, `PPM_SYNC_MASK);
        rd(4'h8, 8'h00);
        $display("test pin routing done");
        wb(`PPM_OFF_A_DIR, 1'b1, 8'hff, 4'h1);
        wb(`PPM_OFF_A_DATA, 1'b1, 8'h3c, 4'h1);
        rst_i <= 1'b1;
        tick(2);
        rst_i <= 1'b0;
        rd(`PPM_OFF_A_DIR, 8'h00);
        wb(`PPM_OFF_A_DIR, 1'b1, 8'hff, 4'h1);
        tick(2);
        chk(32'(a_o), 32'h3c);
        $display("test mid-run reset done");
        tick(4);
        conclude();
    end
endmodule // testbench
bind ppm_ports ppm_checker ppm_checker_i (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .first_port_lines_oe_o(first_port_lines_oe_o),
    .second_port_lines_o(second_port_lines_o),
    .second_port_lines_oe_o(second_port_lines_oe_o),
    .third_port_lines_o(third_port_lines_o),
    .third_port_lines_oe_o(third_port_lines_oe_o),
    .fourth_port_lines_o(fourth_port_lines_o),
    .fourth_port_lines_oe_o(fourth_port_lines_oe_o), .alt_i(alt_i),
    .pulse_width_route_bits_o(pulse_width_route_bits_o),
    .horizontal_sync_out_route_o(horizontal_sync_out_route_o),
    .serial_route_o(serial_route_o));
